// ### rtl/dlsf_top.v
// Status and error flag bank of a dual DAC with a serial link receiver.
// Assumes the serial control port core presents a decoded register access
// (address, read and write strobes) on clock_i, and that all status and
// configuration inputs come from logic on the same clock.
`timescale 1ns/1ps
`include "dlsf_regs.vh"

module dlsf_top (
	// Clock and reset
	input  wire                      clock_i,
	input  wire                      rst_n_i,
	// Register access from the serial control port
	input  wire [`DLSF_ADDR_W-1:0]   reg_addr_i,
	input  wire                      reg_wr_i,
	input  wire [7:0]                reg_wdata_i,
	input  wire                      reg_rd_i,
	output reg  [7:0]                reg_rdata_o,
	// Alignment conditions and their interrupt enables
	input  wire                      align_rotated_i,
	input  wire                      outside_window_i,
	input  wire                      align_tripped_i,
	input  wire                      align_rotated_irq_en_i,
	input  wire                      outside_window_irq_en_i,
	input  wire                      align_tripped_irq_en_i,
	// Datapath overflow conditions
	input  wire                      prog_filter_ovf_i,
	input  wire                      interp_stage_one_ovf_i,
	input  wire                      interp_stage_two_ovf_i,
	input  wire                      interp_stage_three_ovf_i,
	input  wire                      coarse_mixer_ovf_i,
	input  wire                      fine_mixer_ovf_i,
	input  wire                      phase_trim_ovf_i,
	input  wire                      gain_trim_ovf_i,
	input  wire                      offset_trim_ovf_i,
	// Current link configuration settings
	input  wire [7:0]                frame_clock_delay_setting_i,
	input  wire [5:0]                frames_per_multiframe_i,
	input  wire [2:0]                window_limit_i,
	input  wire [3:0]                converters_i,
	input  wire [3:0]                lanes_i,
	input  wire [3:0]                samples_per_frame_i,
	input  wire [3:0]                octets_per_frame_i,
	input  wire [2:0]                subclass_i,
	input  wire [3:0]                interp_factor_i,
	// Interrupt
	output reg                       irq_n_o
);

	wire [2:0] align_flag;
	wire [2:0] align_latched;
	wire [2:0] align_cond;
	wire [2:0] align_en;
	wire [2:0] align_clear;

	reg  [7:0] ovf_a_r;
	reg  [7:0] ovf_a_nxt;
	reg  [7:0] ovf_b_r;
	reg  [7:0] ovf_b_nxt;
	reg  [7:0] link_chk_r;
	reg  [7:0] link_chk_nxt;
	reg  [7:0] rdata_nxt;

	wire       wr_align;
	wire       irq_any;

	// One flag per link check, packed into the register below
	wire       err_dly_over_k;
	wire       err_win_limit;
	wire       err_combo;
	wire       err_k_value;
	wire       err_subclass;
	wire       err_interp;

	// Interpolation factor must be a power of two up to eight
	function is_pow2_upto8;
		input [3:0] v;
		begin
			is_pow2_upto8 = (v == 4'h1) || (v == 4'h2) || (v == 4'h4) || (v == 4'h8);
		end
	endfunction

	// Only the two multiframe lengths the alignment logic can count
	function k_supported;
		input [5:0] k;
		begin
			k_supported = (k == `DLSF_K_SMALL) || (k == `DLSF_K_LARGE);
		end
	endfunction

	// Supported combination: one or two converters, 1/2/4 lanes, one or two
	// samples, and octets per frame times lanes equal to the 16-bit samples (two octets each) per frame.
	function combo_ok;
		input [3:0] m;
		input [3:0] l;
		input [3:0] s;
		input [3:0] f;
		reg   [7:0] payload;
		reg   [7:0] carried;
		reg         m_ok;
		reg         l_ok;
		reg         s_ok;
		begin
			m_ok     = (m == 4'h1) || (m == 4'h2);
			l_ok     = (l == 4'h1) || (l == 4'h2) || (l == 4'h4);
			s_ok     = (s == 4'h1) || (s == 4'h2);
			payload  = {4'h0, m} * {4'h0, s} * `DLSF_OCTETS_PER_SMP;
			carried  = {4'h0, f} * {4'h0, l};
			combo_ok = m_ok && l_ok && s_ok && (f != 4'h0) && (payload == carried);
		end
	endfunction

	// Only the alignment register has writable bits; other writes are dropped
	assign wr_align    = reg_wr_i && (reg_addr_i == `DLSF_OFS_ALIGN_IRQ);
	assign align_cond  = {align_rotated_i, outside_window_i, align_tripped_i};
	assign align_en    = {align_rotated_irq_en_i, outside_window_irq_en_i, align_tripped_irq_en_i};
	assign align_clear = wr_align ? reg_wdata_i[2:0] : 3'h0;
	assign irq_any     = |align_latched;

	// Bit 2 rotate, bit 1 outside window, bit 0 tripped; set wins over clear
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_align
			dlsf_irq_bit u_bit (
				.clock_i   (clock_i),
				.rst_n_i   (rst_n_i),
				.cond_i    (align_cond[gi]),
				.irq_en_i  (align_en[gi]),
				.clear_i   (align_clear[gi]),
				.flag_o    (align_flag[gi]),
				.latched_o (align_latched[gi])
			);
		end
	endgenerate

	// Overflow flags follow the stages; software has no write path to them
	always @* begin
		ovf_a_nxt                         = `DLSF_RESET_VAL;
		ovf_a_nxt[`DLSF_BIT_PROG_FILT]    = prog_filter_ovf_i;
		ovf_a_nxt[`DLSF_BIT_INTERP1]      = interp_stage_one_ovf_i;
		ovf_a_nxt[`DLSF_BIT_INTERP2]      = interp_stage_two_ovf_i;
		ovf_a_nxt[`DLSF_BIT_INTERP3]      = interp_stage_three_ovf_i;
		ovf_a_nxt[`DLSF_BIT_COARSE_MIX]   = coarse_mixer_ovf_i;
		ovf_a_nxt[`DLSF_BIT_FINE_MIX]     = fine_mixer_ovf_i;
		ovf_a_nxt[`DLSF_BIT_PHASE_TRIM]   = phase_trim_ovf_i;
		ovf_a_nxt[`DLSF_BIT_GAIN_TRIM]    = gain_trim_ovf_i;
		ovf_b_nxt                         = `DLSF_RESET_VAL;
		ovf_b_nxt[`DLSF_BIT_OFFSET_TRIM]  = offset_trim_ovf_i;
	end

	// Recomputed every cycle so a corrected setting drops its flag
	assign err_dly_over_k = (frame_clock_delay_setting_i > {2'h0, frames_per_multiframe_i});
	assign err_win_limit  = (window_limit_i > `DLSF_WIN_LIMIT_MAX);
	assign err_combo      = !combo_ok(converters_i, lanes_i, samples_per_frame_i, octets_per_frame_i);
	assign err_k_value    = !k_supported(frames_per_multiframe_i);
	assign err_subclass   = (subclass_i > 3'h1);
	assign err_interp     = !is_pow2_upto8(interp_factor_i);

	// Reserved bits 7:6 stay at their reset value
	always @* begin
		link_chk_nxt                       = `DLSF_RESET_VAL;
		link_chk_nxt[`DLSF_BIT_DLY_OVER_K] = err_dly_over_k;
		link_chk_nxt[`DLSF_BIT_WIN_LIMIT]  = err_win_limit;
		link_chk_nxt[`DLSF_BIT_COMBO]      = err_combo;
		link_chk_nxt[`DLSF_BIT_K_VALUE]    = err_k_value;
		link_chk_nxt[`DLSF_BIT_SUBCLASS]   = err_subclass;
		link_chk_nxt[`DLSF_BIT_INTERP]     = err_interp;
	end

	// Read data is held between reads; unmapped offsets read zero
	always @* begin
		rdata_nxt = reg_rdata_o;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`DLSF_OFS_ALIGN_IRQ: begin
					rdata_nxt = {5'h00, align_flag};
				end
				`DLSF_OFS_OVF_A: begin
					rdata_nxt = ovf_a_r;
				end
				`DLSF_OFS_OVF_B: begin
					rdata_nxt = ovf_b_r;
				end
				`DLSF_OFS_LINK_CHK: begin
					rdata_nxt = link_chk_r;
				end
				default: begin
					rdata_nxt = `DLSF_RESET_VAL;
				end
			endcase
		end
	end

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			ovf_a_r     <= `DLSF_RESET_VAL;
			ovf_b_r     <= `DLSF_RESET_VAL;
			link_chk_r  <= `DLSF_RESET_VAL;
			reg_rdata_o <= `DLSF_RESET_VAL;
			irq_n_o     <= 1'h1;
		end else begin
			ovf_a_r     <= ovf_a_nxt;
			ovf_b_r     <= ovf_b_nxt;
			link_chk_r  <= link_chk_nxt;
			reg_rdata_o <= rdata_nxt;
			// Registered so the pin cannot glitch while several flags change at once
			irq_n_o     <= ~irq_any;
		end
	end

endmodule

// ### rtl/dlsf_regs.vh
// Constants of the link status and datapath flag bank.
// Included by the bank and by anything that decodes its register map.
`ifndef DLSF_REGS_VH
`define DLSF_REGS_VH

// Register offsets
`define DLSF_ADDR_W          12
`define DLSF_OFS_ALIGN_IRQ   12'h025
`define DLSF_OFS_OVF_A       12'h026
`define DLSF_OFS_OVF_B       12'h027
`define DLSF_OFS_LINK_CHK    12'h030

// Alignment flag bit positions
`define DLSF_BIT_ROTATED     2
`define DLSF_BIT_OUTSIDE     1
`define DLSF_BIT_TRIPPED     0

// First overflow register bit positions
`define DLSF_BIT_PROG_FILT   7
`define DLSF_BIT_INTERP1     6
`define DLSF_BIT_INTERP2     5
`define DLSF_BIT_INTERP3     4
`define DLSF_BIT_COARSE_MIX  3
`define DLSF_BIT_FINE_MIX    2
`define DLSF_BIT_PHASE_TRIM  1
`define DLSF_BIT_GAIN_TRIM   0

// Second overflow register
`define DLSF_BIT_OFFSET_TRIM 0

// Link check bit positions
`define DLSF_BIT_DLY_OVER_K  5
`define DLSF_BIT_WIN_LIMIT   4
`define DLSF_BIT_COMBO       3
`define DLSF_BIT_K_VALUE     2
`define DLSF_BIT_SUBCLASS    1
`define DLSF_BIT_INTERP      0

// Reset value of every register
`define DLSF_RESET_VAL       8'h00

// Accepted configuration values
`define DLSF_K_SMALL         6'h10
`define DLSF_K_LARGE         6'h20
`define DLSF_WIN_LIMIT_MAX   3'h5
`define DLSF_OCTETS_PER_SMP  8'h02

`endif

// ### rtl/dlsf_irq_bit.v
// One alignment status bit: live when its enable is low, else latched.
// Condition and controls come from logic on the same clock.
`timescale 1ns/1ps

module dlsf_irq_bit (
	// Clock and reset
	input  wire clock_i,
	input  wire rst_n_i,
	// Condition and control
	input  wire cond_i,
	input  wire irq_en_i,
	input  wire clear_i,
	// Status
	output wire flag_o,
	output wire latched_o
);

	reg cond_r;
	reg latch_r;
	reg latch_nxt;

	// Rising edge only counts once the enable is high
	always @* begin
		latch_nxt = latch_r;
		if (!irq_en_i) begin
			latch_nxt = 1'h0;
		end else if (cond_i && !cond_r) begin
			latch_nxt = 1'h1;
		end else if (clear_i) begin
			latch_nxt = 1'h0;
		end
	end

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			cond_r  <= 1'h0;
			latch_r <= 1'h0;
		end else begin
			cond_r  <= cond_i;
			latch_r <= latch_nxt;
		end
	end

	// Live view is the registered condition, one cycle behind the input
	assign flag_o    = irq_en_i ? latch_r : cond_r;
	assign latched_o = latch_r;

endmodule

// ### tb/dlsf_cfg_model.sv
// Link partner model: supplies the link settings the bank checks.
// Bench picks one setting set per mode; 0 is legal, 7 legal at limits.
`timescale 1ns/1ps

module dlsf_cfg_model (
	input  logic [2:0]  mode_i,
	output logic [39:0] cfg_o
);
	// Order: delay, K, window, M, L, S, F, subclass, interp
	always_comb begin
		cfg_o = {8'h08, 6'h10, 3'h0, 4'h2, 4'h4, 4'h1, 4'h1, 3'h1, 4'h2};
		case (mode_i)
			3'h1: cfg_o[39:32] = 8'h11;
			3'h2: cfg_o[25:23] = 3'h6;
			3'h3: cfg_o[22:19] = 4'h3;
			3'h4: cfg_o[31:26] = 6'h18;
			3'h5: cfg_o[6:4] = 3'h2;
			3'h6: cfg_o[3:0] = 4'h3;
			3'h7: cfg_o = {8'h20, 6'h20, 3'h5, 4'h1, 4'h2, 4'h1, 4'h1, 3'h0, 4'h8};
			default: ;
		endcase
	end
endmodule

// ### tb/dlsf_chk_sva.sv
// Checker for the flag bank: reads, link checks and interrupt.
// Sees only top-level ports; bound onto every dlsf_top.
`timescale 1ns/1ps

module dlsf_chk (
	input logic        clock_i,
	input logic        rst_n_i,
	input logic [11:0] reg_addr_i,
	input logic        reg_rd_i,
	input logic        reg_wr_i,
	input logic [7:0]  reg_rdata_o,
	input logic        irq_n_o,
	input logic        align_tripped_i,
	input logic        align_tripped_irq_en_i,
	input logic        offset_trim_ovf_i,
	input logic [7:0]  frame_clock_delay_setting_i,
	input logic [5:0]  frames_per_multiframe_i,
	input logic [2:0]  window_limit_i,
	input logic [2:0]  subclass_i,
	input logic [3:0]  interp_factor_i
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// Settings must be steady so the read sees the same values we do
	sequence s_chk;
		reg_rd_i && reg_addr_i == 12'h030 && $past(rst_n_i) && $stable({frame_clock_delay_setting_i,
			frames_per_multiframe_i, window_limit_i, subclass_i, interp_factor_i});
	endsequence
	sequence s_rise;
		$past(rst_n_i) && $past(align_tripped_irq_en_i) && align_tripped_irq_en_i && $rose(align_tripped_i);
	endsequence
	sequence s_hold;
		(align_tripped_irq_en_i && !reg_wr_i) [*3];
	endsequence
	property p_idle; disable iff (1'b0) !rst_n_i |=> irq_n_o; endproperty
	property p_trip; s_rise ##1 s_hold |-> !irq_n_o; endproperty
	property p_dly; s_chk |=> reg_rdata_o[5] == ($past(frame_clock_delay_setting_i) > $past(frames_per_multiframe_i)); endproperty
	property p_win; s_chk |=> reg_rdata_o[7:6] == 2'h0 && reg_rdata_o[4] == ($past(window_limit_i) > 3'h5); endproperty
	property p_k; s_chk |=> reg_rdata_o[2] == !($past(frames_per_multiframe_i) inside {6'h10, 6'h20}); endproperty
	property p_sub; s_chk |=> reg_rdata_o[1] == ($past(subclass_i) > 3'h1); endproperty
	property p_int; s_chk |=> reg_rdata_o[0] == !($past(interp_factor_i) inside {4'h1, 4'h2, 4'h4, 4'h8}); endproperty
	property p_ovfb;
		reg_rd_i && reg_addr_i == 12'h027 && $past(rst_n_i) && $stable(offset_trim_ovf_i)
			|=> reg_rdata_o == {7'h00, $past(offset_trim_ovf_i)};
	endproperty
	a_idle: assert property (p_idle) else $error("irq not idle after reset");
	a_trip: assert property (p_trip) else $error("irq not low after tripped rise");
	a_dly: assert property (p_dly) else $error("delay check bit wrong");
	a_win: assert property (p_win) else $error("window check bit wrong");
	a_k: assert property (p_k) else $error("K check bit wrong");
	a_sub: assert property (p_sub) else $error("subclass check bit wrong");
	a_int: assert property (p_int) else $error("interp check bit wrong");
	a_ovfb: assert property (p_ovfb) else $error("second overflow register wrong");
endmodule

bind dlsf_top dlsf_chk chk_i (
	.clock_i                     (clock_i),
	.rst_n_i                     (rst_n_i),
	.reg_addr_i                  (reg_addr_i),
	.reg_rd_i                    (reg_rd_i),
	.reg_wr_i                    (reg_wr_i),
	.reg_rdata_o                 (reg_rdata_o),
	.irq_n_o                     (irq_n_o),
	.align_tripped_i             (align_tripped_i),
	.align_tripped_irq_en_i      (align_tripped_irq_en_i),
	.offset_trim_ovf_i           (offset_trim_ovf_i),
	.frame_clock_delay_setting_i (frame_clock_delay_setting_i),
	.frames_per_multiframe_i     (frames_per_multiframe_i),
	.window_limit_i              (window_limit_i),
	.subclass_i                  (subclass_i),
	.interp_factor_i             (interp_factor_i)
);

// ### tb/dlsf_top_bench.sv
// Self-checking bench for the flag bank.
// Drives the decoded register port; partner model supplies settings.
`timescale 1ns/1ps

module dlsf_top_bench;
	logic        clock_i = 0;
	logic        rst_n_i = 0;
	logic [11:0] addr = 0;
	logic        wr = 0;
	logic        rd = 0;
	logic [7:0]  wdata = 0;
	logic [7:0]  rdata;
	logic [2:0]  al = 0;
	logic [2:0]  en = 0;
	logic [2:0]  mode = 0;
	logic [8:0]  ovf = 0;
	logic        irq_n;
	logic [39:0] cfg;
	int          err_count = 0;
	int          num_checks = 0;
	logic [7:0]  exp_chk [8] = '{8'h00, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00};

	initial forever #2.5 clock_i = ~clock_i;

	dlsf_cfg_model far (.mode_i(mode), .cfg_o(cfg));
	dlsf_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .align_rotated_i(al[2]), .outside_window_i(al[1]),
		.align_tripped_i(al[0]), .align_rotated_irq_en_i(en[2]), .outside_window_irq_en_i(en[1]),
		.align_tripped_irq_en_i(en[0]), .prog_filter_ovf_i(ovf[7]), .interp_stage_one_ovf_i(ovf[6]),
		.interp_stage_two_ovf_i(ovf[5]), .interp_stage_three_ovf_i(ovf[4]), .coarse_mixer_ovf_i(ovf[3]),
		.fine_mixer_ovf_i(ovf[2]), .phase_trim_ovf_i(ovf[1]), .gain_trim_ovf_i(ovf[0]),
		.offset_trim_ovf_i(ovf[8]), .frame_clock_delay_setting_i(cfg[39:32]),
		.frames_per_multiframe_i(cfg[31:26]), .window_limit_i(cfg[25:23]), .converters_i(cfg[22:19]),
		.lanes_i(cfg[18:15]), .samples_per_frame_i(cfg[14:11]), .octets_per_frame_i(cfg[10:7]),
		.subclass_i(cfg[6:4]), .interp_factor_i(cfg[3:0]), .irq_n_o(irq_n));

	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	// Read is taken at the first edge; the data has stood a full cycle when looked at
	task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1;
		tick(1);
		rd <= 0;
		tick(1);
		chk("rdata", rdata, e);
	endtask
	// Strobe drops for one edge so back-to-back calls never drive it twice at once
	task automatic wr_do(input logic [11:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1;
		tick(1);
		wr <= 0;
		tick(1);
	endtask
	// Writes of ff to the four registers and one unmapped offset must leave them all reading zero
	task automatic t_regs;
		logic [11:0] adr [5] = '{12'h025, 12'h026, 12'h027, 12'h030, 12'h031};
		foreach (adr[i]) wr_do(adr[i], 8'hff);
		foreach (adr[i]) rd_chk(adr[i], 8'h00);
	endtask
	task automatic t_ovf;
		for (int i = 0; i < 10; i++) begin
			ovf <= (i < 9) ? 9'h001 << i : 9'h000;
			tick(3);
			rd_chk(12'h026, (i < 8) ? 8'h01 << i : 8'h00);
			if (i >= 8) rd_chk(12'h027, (i == 8) ? 8'h01 : 8'h00);
		end
	endtask
	task automatic t_chk;
		for (int m = 0; m < 9; m++) begin
			mode <= 3'(m % 8);
			tick(3);
			rd_chk(12'h030, exp_chk[m % 8]);
		end
	endtask
	task automatic t_align;
		for (int i = 0; i < 3; i++) begin
			al[i] <= 1;
			tick(3);
			rd_chk(12'h025, 8'h01 << i);
			al[i] <= 0;
			en[i] <= 1;
			tick(3);
			al[i] <= 1;
			tick(4);
			chk("irq_n", {7'h00, irq_n}, 8'h00);
			al[i] <= 0;
			tick(3);
			chk("irq_n", {7'h00, irq_n}, 8'h00);
			rd_chk(12'h025, 8'h01 << i);
			wr_do(12'h025, 8'h01 << i);
			tick(3);
			chk("irq_n", {7'h00, irq_n}, 8'h01);
			rd_chk(12'h025, 8'h00);
			en[i] <= 0;
		end
	endtask
	// Enable raised over a standing condition must not latch; a rise wins over a clear
	task automatic t_edge;
		al[0] <= 1;
		tick(3);
		en[0] <= 1;
		tick(4);
		chk("irq_n", {7'h00, irq_n}, 8'h01);
		rd_chk(12'h025, 8'h00);
		al[0] <= 0;
		tick(2);
		al[0] <= 1;
		addr <= 12'h025;
		wdata <= 8'h01;
		wr <= 1;
		tick(1);
		wr <= 0;
		tick(4);
		chk("irq_n", {7'h00, irq_n}, 8'h00);
		wr_do(12'h025, 8'h01);
		tick(2);
		chk("irq_n", {7'h00, irq_n}, 8'h01);
		al[0] <= 0;
		en[0] <= 0;
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		tick(5);
		rst_n_i <= 1;
		tick(1);
		t_regs();
		t_ovf();
		t_chk();
		t_align();
		t_edge();
		final_report();
	end
	// Whole run is a few hundred cycles
	initial begin
		#20000;
		err_count++;
		final_report();
	end
endmodule
